// ==== verilog/smoke_decision_filter.sv ====
// Per-detector decision filter, alarm compare, smouldering timer, daily factor.
// Assumes samples, config and midnight strobe come from logic on i_clk.
`timescale 1ns/1ps
module smoke_decision_filter
    import smoke_filter_pkg::*;
#(
    parameter int N_DET = 16,
    parameter int IDX_W = 4,
    parameter int SW = 10,
    parameter int CNT_W = 16,
    parameter longint unsigned MIN_CYCLES = MINUTE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Per-detector algorithm configuration
    input wire logic i_cfg_we,
    input wire logic [IDX_W-1:0] i_cfg_idx,
    input wire logic [ALG_W-1:0] i_cfg_alg,
    input wire logic [ALG_W-1:0] i_cfg_alt_alg,
    input wire logic i_cfg_family,
    // System offsets
    input wire logic [SW-1:0] i_fire_offset,
    input wire logic [SW-1:0] i_prewarn_offset,
    input wire logic [SW-1:0] i_smoulder_offset,
    input wire logic i_time_channel,
    // Polled samples
    input wire logic i_sample_valid,
    input wire logic [IDX_W-1:0] i_sample_idx,
    input wire logic [SW-1:0] i_sample,
    input wire logic [SW-1:0] i_week_avg,
    output logic o_sample_ready,
    // Midnight strobe
    input wire logic i_midnight,
    // Per-poll results
    output logic o_result_valid,
    output logic [IDX_W-1:0] o_result_idx,
    output logic [SW-1:0] o_decision,
    output logic o_prewarn,
    output logic o_fire,
    output logic [1:0] o_smoulder_phase,
    // Daily performance factor
    output logic o_perf_valid,
    output logic [IDX_W-1:0] o_perf_idx,
    output logic [PERF_W-1:0] o_perf
);

    localparam int TW = SW + 2;
    localparam int SUM_W = SW + CNT_W;

    typedef struct packed {
        ctrl_state_t st;
        logic [IDX_W-1:0] scan;
        logic [63:0] cyc;
        logic [MIN_W-1:0] minute;
        logic res_valid;
        logic [IDX_W-1:0] res_idx;
        logic [SW-1:0] dec;
        logic pre;
        logic fire;
        logic [1:0] phase;
        logic perf_valid;
        logic [IDX_W-1:0] perf_idx;
        logic [PERF_W-1:0] perf;
    } ctrl_t;

    ctrl_t s_q, s_d;

    // Per-detector memories
    logic [SW-1:0] dec_mem [N_DET];
    smoulder_t phase_mem [N_DET];
    logic [MIN_W-1:0] start_mem [N_DET];
    logic [ALG_W-1:0] alg_mem [N_DET];
    logic [ALG_W-1:0] alt_mem [N_DET];
    logic fam_mem [N_DET];
    logic [SUM_W-1:0] sum_mem [N_DET];
    logic [CNT_W-1:0] cnt_mem [N_DET];

    // Working values for the detector being polled or scanned
    logic take;
    logic [ALG_W-1:0] alg;
    logic [STEP_W-1:0] step;
    logic [SW-1:0] cur, dec_new, diff;
    logic [TW-1:0] smo_lvl, pre_lvl, fire_lvl, pre_in, fire_in;
    smoulder_t ph_new;
    logic [MIN_W-1:0] elapsed, start_new;
    logic [SW-1:0] dev;
    logic [SUM_W-1:0] sum_div;
    logic [SUM_W-1:0] quot;

    ////////////////////////////////////////////////////////////////////////
    // Handshake: polls refused while the midnight scan owns the memories
    assign o_sample_ready = (s_q.st == ST_RUN) && !i_midnight;
    assign take = i_sample_valid && o_sample_ready;

    ////////////////////////////////////////////////////////////////////////
    // Step value from the algorithm in force
    always_comb begin
        alg = i_time_channel ? alt_mem[i_sample_idx] : alg_mem[i_sample_idx];
        if (alg[ALG_SLOW_BIT]) begin
            step = fam_mem[i_sample_idx] ? STEP_B_SLOW : STEP_A_SLOW;
        end else begin
            case (alg[1:0])
                SENS_HIGH: step = fam_mem[i_sample_idx] ? STEP_B_HIGH : STEP_A_HIGH;
                SENS_LOW: step = fam_mem[i_sample_idx] ? STEP_B_LOW : STEP_A_LOW;
                default: step = fam_mem[i_sample_idx] ? STEP_B_NORMAL : STEP_A_NORMAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slew-limited decision value
    always_comb begin
        cur = dec_mem[i_sample_idx];
        diff = (i_sample >= cur) ? i_sample - cur : cur - i_sample;
        if (diff <= SW'(step)) begin
            dec_new = i_sample;
        end else if (i_sample > cur) begin
            dec_new = cur + SW'(step);
        end else begin
            dec_new = cur - SW'(step);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Thresholds track the week average; widened so sums never wrap
    always_comb begin
        smo_lvl = TW'(i_week_avg) + TW'(i_smoulder_offset);
        pre_lvl = TW'(i_week_avg) + TW'(i_prewarn_offset);
        fire_lvl = TW'(i_week_avg) + TW'(i_fire_offset);
        case (phase_mem[i_sample_idx])
            SM_LOWER1: begin
                pre_in = TW'((pre_lvl + smo_lvl) >> 1);
                fire_in = TW'((fire_lvl + pre_lvl) >> 1);
            end
            SM_LOWER2: begin
                pre_in = smo_lvl;
                fire_in = pre_lvl;
            end
            default: begin
                pre_in = pre_lvl;
                fire_in = fire_lvl;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Smouldering sequencer, stepped only when this detector is polled
    always_comb begin
        elapsed = s_q.minute - start_mem[i_sample_idx];
        ph_new = phase_mem[i_sample_idx];
        start_new = start_mem[i_sample_idx];
        if (TW'(dec_new) <= smo_lvl) begin
            ph_new = SM_IDLE;
        end else begin
            case (phase_mem[i_sample_idx])
                SM_IDLE: begin
                    ph_new = SM_ARMED;
                    start_new = s_q.minute;
                end
                SM_ARMED: begin
                    if (elapsed >= MIN_W'(SMOULDER_ARM_MIN)) begin
                        ph_new = SM_LOWER1;
                        start_new = s_q.minute;
                    end
                end
                SM_LOWER1: begin
                    if (elapsed >= MIN_W'(SMOULDER_FIRST_MIN)) begin
                        if (TW'(dec_new) >= pre_in && TW'(dec_new) < fire_in) begin
                            ph_new = SM_LOWER2;
                            start_new = s_q.minute;
                        end else if (TW'(dec_new) < pre_in) begin
                            ph_new = SM_IDLE;
                        end
                    end
                end
                SM_LOWER2: begin
                    if (elapsed >= MIN_W'(SMOULDER_SECOND_MIN)
                            && TW'(dec_new) < fire_in) begin
                        ph_new = SM_IDLE;
                    end
                end
                default: ph_new = SM_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Deviation from week average and midnight mean
    always_comb begin
        dev = (i_sample >= i_week_avg) ? i_sample - i_week_avg : i_week_avg - i_sample;
        sum_div = (cnt_mem[s_q.scan] == '0) ? '0 : SUM_W'(cnt_mem[s_q.scan]);
        quot = (sum_div == '0) ? '0 : sum_mem[s_q.scan] / sum_div;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control state and registered outputs
    always_comb begin
        s_d = s_q;
        s_d.res_valid = 1'b0;
        s_d.perf_valid = 1'b0;
        // Free-running minute base shared by all detector timers
        if (s_q.cyc >= MIN_CYCLES - 64'd1) begin
            s_d.cyc = '0;
            s_d.minute = s_q.minute + MIN_W'(1);
        end else begin
            s_d.cyc = s_q.cyc + 64'd1;
        end
        if (take) begin
            s_d.res_valid = 1'b1;
            s_d.res_idx = i_sample_idx;
            s_d.dec = dec_new;
            s_d.pre = TW'(dec_new) >= pre_in;
            s_d.fire = TW'(dec_new) >= fire_in;
            s_d.phase = ph_new;
        end
        case (s_q.st)
            ST_RUN: begin
                if (i_midnight) begin
                    s_d.st = ST_SCAN;
                    s_d.scan = '0;
                end
            end
            ST_SCAN: begin
                s_d.perf_valid = 1'b1;
                s_d.perf_idx = s_q.scan;
                s_d.perf = (quot > SUM_W'(PERF_MAX)) ? PERF_MAX : PERF_W'(quot);
                s_d.scan = s_q.scan + IDX_W'(1);
                if (s_q.scan == IDX_W'(N_DET - 1)) begin
                    s_d.st = ST_RUN;
                end
            end
            default: s_d.st = ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-detector memories; reset puts every detector at a known start
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < N_DET; i++) begin
                dec_mem[i] <= '0;
                phase_mem[i] <= SM_IDLE;
                start_mem[i] <= '0;
                alg_mem[i] <= ALG_DEFAULT;
                alt_mem[i] <= ALG_DEFAULT;
                fam_mem[i] <= 1'b0;
                sum_mem[i] <= '0;
                cnt_mem[i] <= '0;
            end
        end else begin
            if (i_cfg_we) begin
                alg_mem[i_cfg_idx] <= i_cfg_alg;
                alt_mem[i_cfg_idx] <= i_cfg_alt_alg;
                fam_mem[i_cfg_idx] <= i_cfg_family;
            end
            if (take) begin
                dec_mem[i_sample_idx] <= dec_new;
                phase_mem[i_sample_idx] <= ph_new;
                start_mem[i_sample_idx] <= start_new;
                // Saturate so a missing midnight strobe cannot wrap the mean
                if (cnt_mem[i_sample_idx] != '1) begin
                    sum_mem[i_sample_idx] <= sum_mem[i_sample_idx] + SUM_W'(dev);
                    cnt_mem[i_sample_idx] <= cnt_mem[i_sample_idx] + CNT_W'(1);
                end
            end
            if (s_q.st == ST_SCAN) begin
                sum_mem[s_q.scan] <= '0;
                cnt_mem[s_q.scan] <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign o_result_valid = s_q.res_valid;
    assign o_result_idx = s_q.res_idx;
    assign o_decision = s_q.dec;
    assign o_prewarn = s_q.pre;
    assign o_fire = s_q.fire;
    assign o_smoulder_phase = s_q.phase;
    assign o_perf_valid = s_q.perf_valid;
    assign o_perf_idx = s_q.perf_idx;
    assign o_perf = s_q.perf;

endmodule // smoke_decision_filter

// ==== shared/smoke_filter_pkg.sv ====
// Constants and types for the per-detector smoke decision filter.
// Assumes one clock at 10 MHz and detectors polled one at a time.
package smoke_filter_pkg;

    // Clock and timer bases
    localparam longint unsigned CLK_HZ = 64'd10000000;
    localparam longint unsigned MINUTE_S = 64'd60;
    localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
    localparam int unsigned SMOULDER_ARM_MIN = 7;
    localparam int unsigned SMOULDER_FIRST_MIN = 90;
    localparam int unsigned SMOULDER_SECOND_MIN = 120;
    localparam int MIN_W = 8;

    // Algorithm code: bit 2 = slow detection time, bits 1:0 = sensitivity
    localparam int ALG_W = 3;
    localparam int ALG_SLOW_BIT = 2;
    localparam logic [1:0] SENS_HIGH = 2'h0;
    localparam logic [1:0] SENS_NORMAL = 2'h1;
    localparam logic [1:0] SENS_LOW = 2'h2;
    localparam logic [ALG_W-1:0] ALG_DEFAULT = 3'h1;

    // Step values, first and second detector family
    localparam int STEP_W = 4;
    localparam logic [STEP_W-1:0] STEP_A_HIGH = 4'h4;
    localparam logic [STEP_W-1:0] STEP_A_NORMAL = 4'h5;
    localparam logic [STEP_W-1:0] STEP_A_LOW = 4'h6;
    localparam logic [STEP_W-1:0] STEP_A_SLOW = 4'h2;
    localparam logic [STEP_W-1:0] STEP_B_HIGH = 4'h8;
    localparam logic [STEP_W-1:0] STEP_B_NORMAL = 4'hA;
    localparam logic [STEP_W-1:0] STEP_B_LOW = 4'hC;
    localparam logic [STEP_W-1:0] STEP_B_SLOW = 4'h4;

    // Performance factor ceiling, units of 0.01 %/m
    localparam int PERF_W = 8;
    localparam logic [PERF_W-1:0] PERF_MAX = 8'hFF;

    // Smouldering phases and controller states
    typedef enum logic [1:0] {
        SM_IDLE,
        SM_ARMED,
        SM_LOWER1,
        SM_LOWER2
    } smoulder_t;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_SCAN
    } ctrl_state_t;

endpackage

// ==== tb/smoke_detector_model.sv ====
// Analog smoke detector bank answering polls with its sensed level.
// Assumes the bench calls set() at a rising clock edge.
`timescale 1ns/1ps
module smoke_detector_model #(
    parameter int IDX_W = 4,
    parameter int SW = 10
) (
    // Poll address
    input wire logic i_req,
    input wire logic [IDX_W-1:0] i_idx,
    // Sensor value
    output logic [SW-1:0] o_sample
);
    logic [SW-1:0] level_q [2**IDX_W] = '{default: '0};
    // Unpolled line shows the inverse so stale data never looks valid
    assign o_sample = i_req ? level_q[i_idx] : ~level_q[i_idx];
    // Sets one detector's sensed level
    task automatic set(input int d, input int v);
        level_q[d] <= SW'(v);
    endtask
endmodule // smoke_detector_model

// ==== tb/smoke_decision_filter_chk.sv ====
// Port checker for smoke_decision_filter, bound after the module.
// Assumes prewarn offset is not above fire offset.
`timescale 1ns/1ps
module smoke_decision_filter_chk
    import smoke_filter_pkg::*;
#(
    parameter int N_DET = 16,
    parameter int IDX_W = 4,
    parameter int SW = 10
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Watched inputs
    input wire logic i_sample_valid,
    input wire logic i_midnight,
    input wire logic [SW-1:0] i_week_avg,
    input wire logic [SW-1:0] i_prewarn_offset,
    input wire logic [SW-1:0] i_fire_offset,
    // Watched outputs
    input wire logic o_sample_ready,
    input wire logic o_result_valid,
    input wire logic [SW-1:0] o_decision,
    input wire logic o_prewarn,
    input wire logic o_fire,
    input wire logic o_perf_valid,
    input wire logic [IDX_W-1:0] o_perf_idx
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [SW:0] pre_lvl, fire_lvl, dec_x;
    // Extra bit keeps level sums from wrapping
    assign pre_lvl = (SW+1)'(i_week_avg) + i_prewarn_offset;
    assign fire_lvl = (SW+1)'(i_week_avg) + i_fire_offset;
    assign dec_x = (SW+1)'(o_decision);
    ////////////////////////////////////////////////////////////////////////
    sequence s_take;
        i_sample_valid && o_sample_ready;
    endsequence
    sequence s_first_perf;
        ##2 (o_perf_valid && o_perf_idx == '0);
    endsequence
    property p_reset_clear;
        $fell(i_rst) |-> !o_result_valid && !o_prewarn && !o_fire && o_decision == '0;
    endproperty
    property p_take_answer;
        s_take |=> o_result_valid;
    endproperty
    property p_hold;
        !o_result_valid |-> $stable(o_decision) && $stable(o_prewarn) && $stable(o_fire);
    endproperty
    property p_pre_level;
        o_result_valid && dec_x >= $past(pre_lvl) |-> o_prewarn;
    endproperty
    property p_fire_level;
        o_result_valid && dec_x >= $past(fire_lvl) |-> o_fire;
    endproperty
    property p_fire_cause;
        o_result_valid && o_fire |-> dec_x >= $past(pre_lvl);
    endproperty
    property p_mid_refuse;
        i_midnight |-> !o_sample_ready;
    endproperty
    property p_scan_start;
        i_midnight && $past(o_sample_ready) |-> s_first_perf;
    endproperty
    property p_scan_step;
        o_perf_valid && o_perf_idx < IDX_W'(N_DET - 1)
            |=> o_perf_valid && o_perf_idx == $past(o_perf_idx) + 1'b1;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("dirty after reset");
    a_take_answer: assert property (p_take_answer) else $error("no result");
    a_hold: assert property (p_hold) else $error("result moved");
    a_pre_level: assert property (p_pre_level) else $error("prewarn missing");
    a_fire_level: assert property (p_fire_level) else $error("fire missing");
    a_fire_cause: assert property (p_fire_cause) else $error("fire too low");
    a_mid_refuse: assert property (p_mid_refuse) else $error("ready at midnight");
    a_scan_start: assert property (p_scan_start) else $error("scan late");
    a_scan_step: assert property (p_scan_step) else $error("scan gap");
endmodule // smoke_decision_filter_chk

bind smoke_decision_filter smoke_decision_filter_chk #(
    .N_DET(N_DET), .IDX_W(IDX_W), .SW(SW)
) i_chk (
    .i_clk, .i_rst, .i_sample_valid, .i_midnight, .i_week_avg, .i_prewarn_offset,
    .i_fire_offset, .o_sample_ready, .o_result_valid, .o_decision, .o_prewarn, .o_fire,
    .o_perf_valid, .o_perf_idx
);

// ==== tb/tb.sv ====
// Bench: polls, config and midnight scans, scored from queued notes.
// Assumes one-cycle result latency; minute shortened to 10 cycles.
`timescale 1ns/1ps
module tb;
    import smoke_filter_pkg::*;
    localparam int ND = 16;
    // Inputs, valued at time zero
    logic i_clk = 1'b0, i_rst = 1'b1, i_cfg_we = 1'b0, i_cfg_family = 1'b0;
    logic i_time_channel = 1'b0, i_sample_valid = 1'b0, i_midnight = 1'b0;
    logic [3:0] i_cfg_idx = 4'h0, i_sample_idx = 4'h0;
    logic [2:0] i_cfg_alg = 3'h1, i_cfg_alt_alg = 3'h1;
    logic [9:0] i_fire_offset = 10'h028, i_prewarn_offset = 10'h014;
    logic [9:0] i_smoulder_offset = 10'h258, i_week_avg = 10'h000;
    // Outputs
    logic [9:0] i_sample, o_decision;
    logic o_sample_ready, o_result_valid, o_prewarn, o_fire, o_perf_valid;
    logic [3:0] o_result_idx, o_perf_idx;
    logic [1:0] o_smoulder_phase;
    logic [7:0] o_perf;
    // Reference state per detector
    int dec [ND] = '{default: 0};
    int alg [ND] = '{default: 1};
    int alt [ND] = '{default: 1};
    int fam [ND] = '{default: 0};
    int sum [ND] = '{default: 0};
    int cnt [ND] = '{default: 0};
    int codes [6] = '{0, 1, 2, 4, 5, 6};
    int fails = 0, n_checks = 0;
    int lw = 0;
    logic [15:0] q_res [$], q_perf [$];

    always #50 i_clk = ~i_clk;
    smoke_detector_model #(.IDX_W(4), .SW(10)) i_det (
        .i_req(i_sample_valid), .i_idx(i_sample_idx), .o_sample(i_sample));
    smoke_decision_filter #(.MIN_CYCLES(10)) i_dut (
        .i_clk, .i_rst, .i_cfg_we, .i_cfg_idx, .i_cfg_alg, .i_cfg_alt_alg, .i_cfg_family,
        .i_fire_offset, .i_prewarn_offset, .i_smoulder_offset, .i_time_channel,
        .i_sample_valid, .i_sample_idx, .i_sample, .i_week_avg, .o_sample_ready,
        .i_midnight, .o_result_valid, .o_result_idx, .o_decision, .o_prewarn, .o_fire,
        .o_smoulder_phase, .o_perf_valid, .o_perf_idx, .o_perf);
    ////////////////////////////////////////////////////////////////////////
    // Shared scoring; case compare, so an unknown matches only the same unknown
    task automatic cmp(logic [15:0] got, logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_res(logic [15:0] got);
        cmp(got, q_res.size() > 0 ? q_res.pop_front() : 16'hXXXX);
    endtask
    task automatic chk_perf(logic [15:0] got);
        cmp(got, q_perf.size() > 0 ? q_perf.pop_front() : 16'hXXXX);
    endtask
    // Phase of the last polled detector, read once the poll has settled
    task automatic chk_phase(int p);
        @(negedge i_clk);
        cmp(16'(o_smoulder_phase), 16'(p));
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic int step_of(int a, int f);
        if (a[2]) return f ? 4 : 2;
        if (a[1:0] == 0) return f ? 8 : 4;
        if (a[1:0] == 2) return f ? 12 : 6;
        return f ? 10 : 5;
    endfunction
    task automatic cfg(int d, int a, int b, int f);
        @(posedge i_clk);
        i_cfg_we <= 1'b1;
        i_cfg_idx <= 4'(d);
        i_cfg_alg <= 3'(a);
        i_cfg_alt_alg <= 3'(b);
        i_cfg_family <= 1'(f);
        alg[d] = a;
        alt[d] = b;
        fam[d] = f;
        @(posedge i_clk);
        i_cfg_we <= 1'b0;
    endtask
    // Waits out refusal, then notes the expected result at the take edge
    task automatic poll(int d, int s, int wa, bit tc);
        int k, x, st, pre, fir;
        @(posedge i_clk);
        i_sample_valid <= 1'b1;
        i_sample_idx <= 4'(d);
        i_week_avg <= 10'(wa);
        i_time_channel <= tc;
        i_det.set(d, s);
        k = 0;
        do begin
            @(negedge i_clk);
            k++;
        end while (o_sample_ready !== 1'b1 && k < 40);
        if (o_sample_ready !== 1'b1) begin
            fails++;
            stop_test();
        end
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        st = step_of(tc ? alt[d] : alg[d], fam[d]);
        x = s - dec[d];
        dec[d] = x > st ? dec[d] + st : (x < -st ? dec[d] - st : s);
        pre = wa + int'(i_prewarn_offset);
        fir = wa + int'(i_fire_offset);
        if (lw == 1) begin
            fir = (fir + pre) / 2;
            pre = (pre + wa + int'(i_smoulder_offset)) / 2;
        end else if (lw == 2) begin
            fir = pre;
            pre = wa + int'(i_smoulder_offset);
        end
        q_res.push_back({4'(d), 10'(dec[d]), dec[d] >= pre, dec[d] >= fir});
        sum[d] += s > wa ? s - wa : wa - s;
        cnt[d]++;
        if (dec[d] <= wa + int'(i_smoulder_offset)) lw = 0;
    endtask
    task automatic midnight();
        int m;
        @(posedge i_clk);
        i_midnight <= 1'b1;
        for (int d = 0; d < ND; d++) begin
            m = cnt[d] > 0 ? sum[d] / cnt[d] : 0;
            q_perf.push_back({8'h00, 4'(d), 8'(m > 255 ? 255 : m)});
            sum[d] = 0;
            cnt[d] = 0;
        end
        @(posedge i_clk);
        i_midnight <= 1'b0;
    endtask
    // Results and factors are settled by the falling edge
    always @(negedge i_clk) begin
        if (o_result_valid === 1'b1) chk_res({o_result_idx, o_decision, o_prewarn, o_fire});
        if (o_perf_valid === 1'b1) chk_perf({8'h00, o_perf_idx, o_perf});
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int d, s;
        void'($urandom(4104));
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        // Six codes over both families, alternative shifted by one
        for (int n = 0; n < 12; n++) cfg(n, codes[n % 6], codes[(n + 1) % 6], n / 6);
        for (int n = 0; n < 150; n++) begin
            d = $urandom % 12;
            s = dec[d] + int'($urandom % 61) - 20;
            poll(d, s < 0 ? 0 : (s > 500 ? 500 : s), $urandom % 32, $urandom % 2);
        end
        $display("test filter done");
        poll(15, 1000, 0, 0);
        poll(15, 1000, 0, 0);
        midnight();
        poll(2, 3, 1, 0);
        $display("test midnight done");
        // Smouldering on an unconfigured detector: levels 24, 32, 40
        @(posedge i_clk);
        i_prewarn_offset <= 10'h016;
        i_fire_offset <= 10'h01E;
        i_smoulder_offset <= 10'h00E;
        repeat (6) poll(13, 26, 10, 0);
        chk_phase(1);
        repeat (60) poll(13, 26, 10, 0);
        chk_phase(2);
        lw = 1;
        repeat (3) poll(13, 37, 10, 0);
        repeat (4) poll(13, 0, 10, 0);
        chk_phase(0);
        $display("test smoulder done");
        // Long smouldering: idle gaps stand in for minutes between polls
        repeat (3) poll(13, 30, 10, 0);
        repeat (80) @(posedge i_clk);
        poll(13, 30, 10, 0);
        chk_phase(2);
        lw = 1;
        repeat (910) @(posedge i_clk);
        poll(13, 30, 10, 0);
        chk_phase(3);
        lw = 2;
        poll(13, 30, 10, 0);
        repeat (1210) @(posedge i_clk);
        poll(13, 30, 10, 0);
        chk_phase(0);
        lw = 0;
        // Pre-warning never reached within the first long interval
        poll(13, 26, 10, 0);
        repeat (80) @(posedge i_clk);
        poll(13, 26, 10, 0);
        chk_phase(2);
        lw = 1;
        repeat (910) @(posedge i_clk);
        poll(13, 26, 10, 0);
        chk_phase(0);
        lw = 0;
        $display("test smoulder timers done");
        repeat (20) @(posedge i_clk);
        if (q_res.size() + q_perf.size() != 0) fails++;
        stop_test();
    end
endmodule // tb
